// file: logic/ess_regs.vh
// Purpose: register offsets, field positions, encodings and constants
//          of the enclave shadow-stack control block
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes:   definitions only
`ifndef ESS_REGS_VH
`define ESS_REGS_VH

// register byte offsets
`define ESS_CMD_OFF        8'h00
`define ESS_STATUS_OFF     8'h04
`define ESS_ACT_CFG_OFF    8'h08
`define ESS_ENC_CFG_OFF    8'h0C
`define ESS_SCR_CFG_OFF    8'h10
`define ESS_SSA_CFG_OFF    8'h14
`define ESS_SSP_OFF        8'h18
`define ESS_SAVED_SSP_OFF  8'h1C
`define ESS_SCR_SSP_OFF    8'h20
`define ESS_RANGE_BASE_OFF 8'h24
`define ESS_RANGE_SIZE_OFF 8'h28
`define ESS_ACC_ADDR_OFF   8'h2C
`define ESS_ACC_ATTR_OFF   8'h30
`define ESS_PAGE_LA_OFF    8'h34
`define ESS_PAGE_ATTR_OFF  8'h38
`define ESS_PAGE_DATA_OFF  8'h3C
`define ESS_TOKEN_ADDR_OFF 8'h40
`define ESS_TOKEN_VAL_OFF  8'h44
`define ESS_PAGE_META_OFF  8'h48
`define ESS_ERR_CODE_OFF   8'h4C
`define ESS_BITMAP_OFF     8'h50

// commands written to the command register
`define ESS_OP_NONE       4'h0
`define ESS_OP_ENTER      4'h1
`define ESS_OP_AEX        4'h2
`define ESS_OP_EXIT       4'h3
`define ESS_OP_ACCESS     4'h4
`define ESS_OP_DYN_ADD    4'h5
`define ESS_OP_BUILD_ADD  4'h6
`define ESS_OP_ACCEPT     4'h7
`define ESS_OP_ACC_COPY   4'h8
`define ESS_OP_RESTRICT   4'h9
`define ESS_OP_EXTEND     4'hA
`define ESS_OP_BITMAP     4'hB

// page types
`define ESS_PT_SECS     3'h0
`define ESS_PT_TCS      3'h1
`define ESS_PT_REG      3'h2
`define ESS_PT_VA       3'h3
`define ESS_PT_TRIM     3'h4
`define ESS_SHADOW_STACK_FIRST_PAGE_TYPE 3'h5
`define ESS_SHADOW_STACK_CONTINUATION_PAGE_TYPE  3'h6

// access kinds
`define ESS_ACC_LOAD     2'h0
`define ESS_ACC_STORE    2'h1
`define ESS_ACC_SS_LOAD  2'h2
`define ESS_ACC_SS_STORE 2'h3

// fault classes
`define ESS_FLT_NONE 2'h0
`define ESS_FLT_GP   2'h1
`define ESS_FLT_PF   2'h2
`define ESS_FLT_LEAF 2'h3

// field positions
`define ESS_CMD_OP        3:0
`define ESS_ATTR_KIND     1:0
`define ESS_ATTR_PT_W     2
`define ESS_ATTR_EPT_W    3
`define ESS_ATTR_TYPE     6:4
`define ESS_PA_TYPE       2:0
`define ESS_PA_PERM       6:4
`define ESS_PA_PAGE_SECURITY_INFO    8
`define ESS_PA_ZERO       9
`define ESS_ST_IN_ENCL    0
`define ESS_ST_FAULT      2:1
`define ESS_ST_TOKEN      3
`define ESS_PF_WRITE_BIT  1
`define ESS_PF_ENCL_BIT   15

// constants
`define ESS_PERM_RW       3'h3
`define ESS_PAGE_BYTES    32'h0000_1000
`define ESS_PAGE_SHIFT    12
`define ESS_TOKEN_OFFSET  32'h0000_0FF8
`define ESS_HTRANS_NONSEQ 2'h2
`define ESS_ZERO32        32'h0000_0000

`endif

// file: logic/ess_ctrl.v
// Purpose: enclave shadow-stack control: state swap on entry and exit,
//          shadow-stack page access checks, page-add/accept/permission leaf checks
// Assumes: single AHB-Lite master, whole-word single transfers, synchronous reset
// Notes:   every command completes in the cycle after its write
// Operation
// RULE_01: on entry save application state to scratchpad, load enclave's own state
// RULE_02: on asynchronous exit store enclave state into state save area frame
// RULE_03: on any exit restore application state from scratchpad
// RULE_04: accept shadow-stack loads, stores and ordinary loads to shadow-stack pages
// RULE_05: refuse ordinary stores to either shadow-stack page type
// RULE_06: shadow-stack pages usable only if writable in page tables and extended tables
// RULE_07: in enclave, shadow-stack accesses only inside the enclave linear range
// RULE_08: dynamic add makes shadow-stack pages only with security info and read/write
// RULE_09: dynamic add makes regular read/write page with null or matching security info
// RULE_10: dynamic add of first shadow-stack page writes restore token at 0xFF8
// RULE_11: both add leaves refuse shadow-stack pages at lowest or highest range page
// RULE_12: build add needs zero continuation page; first page zero except token
// RULE_13: build add token must equal page linear address plus 4096
// RULE_14: entry loads pointer from saved field; exit writes pointer back
// RULE_15: thread structure added or accepted needs saved pointer field zero
// RULE_16: refuse accept-with-copy, restrict and extend on shadow-stack pages
// RULE_17: legacy bitmap index uses page offset inside the enclave range; outside the enclave the code uses the absolute page number
// RULE_18: shadow-stack access outside range in enclave gives general fault, code zero
// RULE_19: failed page-attribute check gives page fault with enclave bit set
// RULE_20: failed leaf check leaves page and metadata unchanged and reports fault
//
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`include "ess_regs.vh"

module ess_ctrl (
	input wire SYS_CLK, // 10 MHz core clock
	input wire RESET_N, // synchronous reset, active low
	input wire HSEL, // slave select
	input wire [31:0] HADDR, // byte address
	input wire [1:0] HTRANS, // transfer type
	input wire HWRITE, // write not read
	input wire [2:0] HSIZE, // transfer size, word only
	input wire [31:0] HWDATA, // write data
	input wire HREADY, // bus ready
	output reg [31:0] HRDATA, // read data
	output reg HREADYOUT, // slave ready
	output reg HRESP // always okay
);

	reg wr_pend_reg;
	reg rd_pend_reg;
	reg [7:0] addr_reg;
	reg in_encl_reg;
	reg [1:0] fault_reg;
	reg token_made_reg;
	reg [31:0] act_cfg_reg;
	reg [31:0] enc_cfg_reg;
	reg [31:0] scr_cfg_reg;
	reg [31:0] ssa_cfg_reg;
	reg [31:0] ssp_reg;
	reg [31:0] saved_ssp_reg;
	reg [31:0] scr_ssp_reg;
	reg [31:0] range_base_reg;
	reg [31:0] range_size_reg;
	reg [31:0] acc_addr_reg;
	reg [31:0] acc_attr_reg;
	reg [31:0] page_la_reg;
	reg [31:0] page_attr_reg;
	reg [31:0] page_data_reg;
	reg [31:0] token_addr_reg;
	reg [31:0] token_val_reg;
	reg [31:0] page_meta_reg;
	reg [31:0] err_code_reg;
	reg [31:0] bitmap_reg;

	wire addr_phase = HSEL && HREADY && (HTRANS == `ESS_HTRANS_NONSEQ);
	wire cmd_wr = wr_pend_reg && (addr_reg == `ESS_CMD_OFF);
	wire [3:0] op = HWDATA[`ESS_CMD_OP];

	function in_range;
		input [31:0] a;
		input [31:0] base;
		input [31:0] size;
		begin
			in_range = (a >= base) && ((a - base) < size);
		end
	endfunction

	function is_ss_type;
		input [2:0] t;
		begin
			is_ss_type = (t == `ESS_SHADOW_STACK_FIRST_PAGE_TYPE) || (t == `ESS_SHADOW_STACK_CONTINUATION_PAGE_TYPE);
		end
	endfunction

	// true for the lowest or highest page of the range
	function edge_page;
		input [31:0] la;
		input [31:0] base;
		input [31:0] size;
		reg [31:0] last;
		begin
			last = base + size - `ESS_PAGE_BYTES;
			edge_page = (la[31:`ESS_PAGE_SHIFT] == base[31:`ESS_PAGE_SHIFT]) ||
				(la[31:`ESS_PAGE_SHIFT] == last[31:`ESS_PAGE_SHIFT]);
		end
	endfunction

	// access check decode
	wire [1:0] kind = acc_attr_reg[`ESS_ATTR_KIND];
	wire [2:0] acc_type = acc_attr_reg[`ESS_ATTR_TYPE];
	wire ss_kind = (kind == `ESS_ACC_SS_LOAD) || (kind == `ESS_ACC_SS_STORE);
	wire acc_ss_page = is_ss_type(acc_type);
	wire acc_in_range = in_range(acc_addr_reg, range_base_reg, range_size_reg);
	wire mapped_w = acc_attr_reg[`ESS_ATTR_PT_W] && acc_attr_reg[`ESS_ATTR_EPT_W];
	reg [1:0] acc_fault;
	always @* begin
		acc_fault = `ESS_FLT_NONE;
		if (in_encl_reg && ss_kind && !acc_in_range) begin
			acc_fault = `ESS_FLT_GP; // see RULE_07 see RULE_18
		end else if (acc_ss_page) begin
			if (!mapped_w) begin
				acc_fault = `ESS_FLT_PF; // see RULE_06
			end else if (kind == `ESS_ACC_STORE) begin
				acc_fault = `ESS_FLT_PF; // see RULE_05
			end else begin
				acc_fault = `ESS_FLT_NONE; // see RULE_04
			end
		end else if (ss_kind) begin
			acc_fault = `ESS_FLT_PF;
		end
	end

	// page error code carries the enclave indication and the write flag
	wire [31:0] pf_code = (`ESS_ZERO32 | (32'h1 << `ESS_PF_ENCL_BIT)) |
		((kind == `ESS_ACC_STORE || kind == `ESS_ACC_SS_STORE) ?
		(32'h1 << `ESS_PF_WRITE_BIT) : `ESS_ZERO32); // see RULE_19

	// page leaf decode
	wire [2:0] pg_type = page_attr_reg[`ESS_PA_TYPE];
	wire [2:0] pg_perm = page_attr_reg[`ESS_PA_PERM];
	wire page_security_info = page_attr_reg[`ESS_PA_PAGE_SECURITY_INFO];
	wire pg_zero = page_attr_reg[`ESS_PA_ZERO];
	wire pg_ss = is_ss_type(pg_type);
	wire pg_edge = edge_page(page_la_reg, range_base_reg, range_size_reg);
	wire [31:0] token_expect = page_la_reg + `ESS_PAGE_BYTES;

	reg dyn_ok;
	reg [2:0] dyn_type;
	always @* begin
		dyn_ok = 1'b0;
		dyn_type = `ESS_PT_REG;
		if (!page_security_info) begin
			dyn_ok = 1'b1; // see RULE_09
		end else if (pg_type == `ESS_PT_REG) begin
			dyn_ok = (pg_perm == `ESS_PERM_RW); // see RULE_09
		end else if (pg_ss) begin
			dyn_type = pg_type;
			dyn_ok = (pg_perm == `ESS_PERM_RW) && !pg_edge; // see RULE_08 see RULE_11
		end
	end

	reg build_ok;
	always @* begin
		build_ok = 1'b1;
		if (pg_ss && pg_edge) begin
			build_ok = 1'b0; // see RULE_11
		end else if (pg_type == `ESS_SHADOW_STACK_CONTINUATION_PAGE_TYPE) begin
			build_ok = pg_zero; // see RULE_12
		end else if (pg_type == `ESS_SHADOW_STACK_FIRST_PAGE_TYPE) begin
			build_ok = pg_zero && (page_data_reg == token_expect); // see RULE_12 see RULE_13
		end else if (pg_type == `ESS_PT_TCS) begin
			build_ok = (page_data_reg == `ESS_ZERO32); // see RULE_15
		end
	end

	wire accept_ok = (pg_type != `ESS_PT_TCS) ||
		(page_data_reg == `ESS_ZERO32); // see RULE_15

	// bus phase tracking; reads take one wait state so HRDATA can be a flop
	always @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg <= 8'h00;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
			HRDATA <= `ESS_ZERO32;
		end else begin
			HRESP <= 1'b0;
			if (rd_pend_reg) begin
				rd_pend_reg <= 1'b0;
				HREADYOUT <= 1'b1;
				case (addr_reg)
					`ESS_STATUS_OFF: HRDATA <= {28'h0, token_made_reg, fault_reg, in_encl_reg};
					`ESS_ACT_CFG_OFF: HRDATA <= act_cfg_reg;
					`ESS_ENC_CFG_OFF: HRDATA <= enc_cfg_reg;
					`ESS_SCR_CFG_OFF: HRDATA <= scr_cfg_reg;
					`ESS_SSA_CFG_OFF: HRDATA <= ssa_cfg_reg;
					`ESS_SSP_OFF: HRDATA <= ssp_reg;
					`ESS_SAVED_SSP_OFF: HRDATA <= saved_ssp_reg;
					`ESS_SCR_SSP_OFF: HRDATA <= scr_ssp_reg;
					`ESS_RANGE_BASE_OFF: HRDATA <= range_base_reg;
					`ESS_RANGE_SIZE_OFF: HRDATA <= range_size_reg;
					`ESS_ACC_ADDR_OFF: HRDATA <= acc_addr_reg;
					`ESS_ACC_ATTR_OFF: HRDATA <= acc_attr_reg;
					`ESS_PAGE_LA_OFF: HRDATA <= page_la_reg;
					`ESS_PAGE_ATTR_OFF: HRDATA <= page_attr_reg;
					`ESS_PAGE_DATA_OFF: HRDATA <= page_data_reg;
					`ESS_TOKEN_ADDR_OFF: HRDATA <= token_addr_reg;
					`ESS_TOKEN_VAL_OFF: HRDATA <= token_val_reg;
					`ESS_PAGE_META_OFF: HRDATA <= page_meta_reg;
					`ESS_ERR_CODE_OFF: HRDATA <= err_code_reg;
					`ESS_BITMAP_OFF: HRDATA <= bitmap_reg;
					default: HRDATA <= `ESS_ZERO32;
				endcase
				wr_pend_reg <= 1'b0;
			end else if (addr_phase) begin
				addr_reg <= HADDR[7:0];
				wr_pend_reg <= HWRITE && (HADDR[31:8] == 24'h0);
				rd_pend_reg <= !HWRITE;
				HREADYOUT <= HWRITE;
			end else begin
				wr_pend_reg <= 1'b0;
			end
		end
	end

	// plain writable registers
	always @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			enc_cfg_reg <= `ESS_ZERO32;
			range_base_reg <= `ESS_ZERO32;
			range_size_reg <= `ESS_ZERO32;
			acc_addr_reg <= `ESS_ZERO32;
			acc_attr_reg <= `ESS_ZERO32;
			page_la_reg <= `ESS_ZERO32;
			page_attr_reg <= `ESS_ZERO32;
			page_data_reg <= `ESS_ZERO32;
		end else if (wr_pend_reg) begin
			case (addr_reg)
				`ESS_ENC_CFG_OFF: enc_cfg_reg <= HWDATA;
				`ESS_RANGE_BASE_OFF: range_base_reg <= HWDATA;
				`ESS_RANGE_SIZE_OFF: range_size_reg <= HWDATA;
				`ESS_ACC_ADDR_OFF: acc_addr_reg <= HWDATA;
				`ESS_ACC_ATTR_OFF: acc_attr_reg <= HWDATA;
				`ESS_PAGE_LA_OFF: page_la_reg <= HWDATA;
				`ESS_PAGE_ATTR_OFF: page_attr_reg <= HWDATA;
				`ESS_PAGE_DATA_OFF: page_data_reg <= HWDATA;
				default: page_data_reg <= page_data_reg;
			endcase
		end
	end

	// command execution; state swaps and leaf checks finish in one cycle
	always @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			in_encl_reg <= 1'b0;
			fault_reg <= `ESS_FLT_NONE;
			token_made_reg <= 1'b0;
			act_cfg_reg <= `ESS_ZERO32;
			scr_cfg_reg <= `ESS_ZERO32;
			ssa_cfg_reg <= `ESS_ZERO32;
			ssp_reg <= `ESS_ZERO32;
			saved_ssp_reg <= `ESS_ZERO32;
			scr_ssp_reg <= `ESS_ZERO32;
			token_addr_reg <= `ESS_ZERO32;
			token_val_reg <= `ESS_ZERO32;
			page_meta_reg <= `ESS_ZERO32;
			err_code_reg <= `ESS_ZERO32;
			bitmap_reg <= `ESS_ZERO32;
		end else if (cmd_wr) begin
			fault_reg <= `ESS_FLT_NONE;
			err_code_reg <= `ESS_ZERO32;
			case (op)
				`ESS_OP_ENTER: begin
					if (in_encl_reg) begin
						fault_reg <= `ESS_FLT_GP;
					end else begin
						scr_cfg_reg <= act_cfg_reg; // see RULE_01
						act_cfg_reg <= enc_cfg_reg; // see RULE_01
						scr_ssp_reg <= ssp_reg;
						ssp_reg <= saved_ssp_reg; // see RULE_14
						in_encl_reg <= 1'b1;
					end
				end
				`ESS_OP_AEX, `ESS_OP_EXIT: begin
					if (!in_encl_reg) begin
						fault_reg <= `ESS_FLT_GP;
					end else begin
						if (op == `ESS_OP_AEX) begin
							ssa_cfg_reg <= act_cfg_reg; // see RULE_02
						end
						act_cfg_reg <= scr_cfg_reg; // see RULE_03
						saved_ssp_reg <= ssp_reg; // see RULE_14
						ssp_reg <= scr_ssp_reg;
						in_encl_reg <= 1'b0;
					end
				end
				`ESS_OP_ACCESS: begin
					fault_reg <= acc_fault;
					if (acc_fault == `ESS_FLT_PF) begin
						err_code_reg <= pf_code; // see RULE_19
					end
				end
				`ESS_OP_DYN_ADD: begin
					token_made_reg <= 1'b0;
					if (!dyn_ok) begin
						fault_reg <= `ESS_FLT_LEAF; // see RULE_20
					end else begin
						page_meta_reg <= {25'h0, `ESS_PERM_RW, 1'b0, dyn_type};
						if (dyn_type == `ESS_SHADOW_STACK_FIRST_PAGE_TYPE) begin
							token_addr_reg <= page_la_reg + `ESS_TOKEN_OFFSET; // see RULE_10
							token_val_reg <= token_expect; // see RULE_10
							token_made_reg <= 1'b1;
						end
					end
				end
				`ESS_OP_BUILD_ADD: begin
					if (!build_ok) begin
						fault_reg <= `ESS_FLT_LEAF; // see RULE_20
					end else begin
						page_meta_reg <= {25'h0, pg_perm, 1'b0, pg_type};
					end
				end
				`ESS_OP_ACCEPT: begin
					if (!accept_ok) begin
						fault_reg <= `ESS_FLT_LEAF; // see RULE_20
					end
				end
				`ESS_OP_ACC_COPY, `ESS_OP_RESTRICT, `ESS_OP_EXTEND: begin
					if (pg_ss) begin
						fault_reg <= `ESS_FLT_LEAF; // see RULE_16 see RULE_20
					end else begin
						page_meta_reg <= {25'h0, pg_perm, 1'b0, pg_type};
					end
				end
				`ESS_OP_BITMAP: begin
					if (in_encl_reg) begin
						bitmap_reg <= (acc_addr_reg - range_base_reg) >> `ESS_PAGE_SHIFT; // see RULE_17
					end else begin
						bitmap_reg <= acc_addr_reg >> `ESS_PAGE_SHIFT;
					end
				end
				default: fault_reg <= `ESS_FLT_NONE;
			endcase
		end else if (wr_pend_reg) begin
			// application state and pointer are software-owned only outside the enclave
			if (addr_reg == `ESS_ACT_CFG_OFF && !in_encl_reg) begin
				act_cfg_reg <= HWDATA;
			end
			if (addr_reg == `ESS_SSP_OFF && !in_encl_reg) begin
				ssp_reg <= HWDATA;
			end
			if (addr_reg == `ESS_SAVED_SSP_OFF && !in_encl_reg) begin
				saved_ssp_reg <= HWDATA;
			end
		end
	end

endmodule

// file: dv/ess_ctrl_asserts.sv
// Purpose: bus-level checks on the enclave shadow-stack control block
// Assumes: HREADY is tied to HREADYOUT, upper address bits kept zero
// Notes: bound to every ess_ctrl instance
`timescale 1ns/1ps
`include "ess_regs.vh"
module ess_ctrl_chk (
	input wire SYS_CLK, // core clock
	input wire RESET_N, // synchronous reset, active low
	input wire HSEL, // slave select
	input wire [31:0] HADDR, // byte address
	input wire [1:0] HTRANS, // transfer type
	input wire HWRITE, // write not read
	input wire HREADY, // bus ready
	input wire [31:0] HRDATA, // read data
	input wire HREADYOUT, // slave ready
	input wire HRESP // response
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);
	wire acc = HSEL && HREADY && HTRANS == `ESS_HTRANS_NONSEQ;
	reg rd_reg;
	reg wr_reg;
	reg [7:0] adr_reg;
	// data-phase markers, cleared by reset so no stale phase survives it
	always @(posedge SYS_CLK) begin
		rd_reg <= RESET_N && acc && !HWRITE;
		wr_reg <= RESET_N && acc && HWRITE;
		adr_reg <= HADDR[7:0];
	end
	chk_resp_okay: assert property (HRESP == 1'b0)
		else $error("response not okay");
	chk_write_nowait: assert property (wr_reg |-> HREADYOUT)
		else $error("write data phase stalled");
	chk_read_wait: assert property (rd_reg |-> !HREADYOUT ##1 HREADYOUT)
		else $error("read wait state wrong");
	chk_wait_cause: assert property ($fell(HREADYOUT) |-> rd_reg)
		else $error("wait state without a read");
	chk_wait_once: assert property ($fell(HREADYOUT) |=> $rose(HREADYOUT))
		else $error("wait state longer than one cycle");
	chk_ready_idle: assert property ((HREADYOUT && !(acc && !HWRITE)) |=> HREADYOUT)
		else $error("ready dropped without a read");
	chk_rdata_hold: assert property ((HREADYOUT && $past(HREADYOUT) && $past(RESET_N))
		|-> $stable(HRDATA)) else $error("read data changed between reads");
	chk_zero_read: assert property ((rd_reg && (adr_reg == `ESS_CMD_OFF
		|| adr_reg > `ESS_BITMAP_OFF)) |=> HRDATA == 32'h0)
		else $error("command or unmapped read not zero");
endmodule
bind ess_ctrl ess_ctrl_chk u_chk (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .HSEL(HSEL),
	.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP));

// file: dv/ess_ctrl_test.sv
// Purpose: self-checking bench for the enclave shadow-stack control block
// Assumes: one AHB-Lite master, HREADY tied to HREADYOUT
// Notes: reads queue their expectation; a monitor compares on completion
`timescale 1ns/1ps
`include "ess_regs.vh"
module ess_ctrl_test;
	typedef struct {logic [31:0] exp; logic [31:0] msk; string nm;} ess_note_t;
	localparam logic [31:0] FULL = 32'hFFFF_FFFF;
	localparam logic [31:0] AAD[6] = '{32'h0002_0000, 32'h0001_1000, 32'h0001_2000,
		32'h0001_1000, 32'h0001_1008, 32'h0001_2000};
	localparam logic [7:0] AAT[6] = '{8'h5E, 8'h5F, 8'h6C, 8'h5D, 8'h67, 8'h5A};
	localparam logic [1:0] AFT[6] = '{2'h1, 2'h0, 2'h0, 2'h2, 2'h2, 2'h2};
	localparam logic [15:0] AEC[6] = '{16'h0, 16'h0, 16'h0, 16'h8002, 16'h8002, 16'h8000};
	localparam logic [3:0] LOP[19] = '{4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'h6, 4'h6, 4'h6, 4'h6,
		4'h6, 4'h6, 4'h6, 4'h7, 4'h7, 4'h8, 4'h9, 4'hA, 4'h5, 4'h9};
	localparam logic [7:0] LPG[19] = '{8'h11, 8'h11, 8'h11, 8'h10, 8'h13, 8'h12, 8'h12, 8'h11,
		8'h11, 8'h13, 8'h11, 8'h11, 8'h11, 8'h11, 8'h11, 8'h11, 8'h11, 8'h12, 8'h12};
	localparam logic [11:0] LAT[19] = '{12'h000, 12'h135, 12'h116, 12'h135, 12'h136, 12'h336,
		12'h136, 12'h335, 12'h335, 12'h335, 12'h301, 12'h301, 12'h101, 12'h101, 12'h135,
		12'h116, 12'h135, 12'h132, 12'h012};
	localparam logic [19:0] LDT[19] = '{20'h0, 20'h0, 20'h0, 20'h0, 20'h0, 20'h0, 20'h0,
		20'h12000, 20'h11000, 20'h14000, 20'h5, 20'h0, 20'h7, 20'h0, 20'h0, 20'h0, 20'h0,
		20'h0, 20'h0};
	localparam logic [1:0] LFT[19] = '{2'h0, 2'h0, 2'h3, 2'h3, 2'h3, 2'h0, 2'h3, 2'h0, 2'h3,
		2'h3, 2'h3, 2'h0, 2'h3, 2'h0, 2'h3, 2'h3, 2'h3, 2'h0, 2'h0};
	localparam logic [7:0] LMT[19] = '{8'h32, 8'h35, 8'h35, 8'h35, 8'h35, 8'h36, 8'h36, 8'h35,
		8'h35, 8'h35, 8'h35, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h32, 8'h12};
	logic SYS_CLK = 1'b0;
	logic RESET_N = 1'b0;
	logic HSEL = 1'b0;
	logic [31:0] HADDR = 32'h0;
	logic [1:0] HTRANS = 2'h0;
	logic HWRITE = 1'b0;
	logic [31:0] HWDATA = 32'h0;
	wire [31:0] HRDATA;
	wire HREADYOUT;
	wire HRESP;
	int failures = 0;
	int n_checks = 0;
	ess_note_t notes[$];
	logic dph_rd = 1'b0;
	logic [31:0] seed = 32'h0000_0044;
	logic [31:0] cfg[4];
	ess_ctrl dut (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP));
	initial begin
		forever #50 SYS_CLK = ~SYS_CLK;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d, failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic cmp_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// read data stands while ready is high in the read data phase
	always @(posedge SYS_CLK) begin
		ess_note_t n;
		if (dph_rd && HREADYOUT === 1'b1 && notes.size() > 0) begin
			n = notes.pop_front();
			cmp_word(n.nm, n.exp & n.msk, HRDATA & n.msk);
		end
		if (HREADYOUT === 1'b1) dph_rd <= RESET_N && HSEL && HTRANS == 2'h2 && !HWRITE;
	end
	// ready is sampled at the rising edge; only the watchdog ends a wait that never returns
	task automatic wait_rdy;
		do begin
			@(posedge SYS_CLK);
		end while (HREADYOUT !== 1'b1);
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		HSEL <= 1'b1;
		HTRANS <= `ESS_HTRANS_NONSEQ;
		HADDR <= {24'h0, a};
		HWRITE <= w;
		wait_rdy;
		HTRANS <= 2'h0;
		HWDATA <= d;
		wait_rdy;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input string nm);
		notes.push_back('{e, m, nm});
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic st(input logic [31:0] e, input logic [31:0] m);
		rd(`ESS_STATUS_OFF, e, m, "status");
	endtask
	task automatic cmd(input logic [3:0] op);
		wr(`ESS_CMD_OFF, {28'h0, op});
	endtask
	initial begin
		int i;
		repeat (4) @(posedge SYS_CLK);
		RESET_N <= 1'b1;
		for (i = 0; i <= 8'h54; i += 4) rd(i[7:0], 32'h0, FULL, "reset value");
		for (i = 0; i < 4; i++) begin
			seed = xs(seed);
			cfg[i] = seed;
		end
		wr(`ESS_RANGE_BASE_OFF, 32'h0001_0000);
		wr(`ESS_RANGE_SIZE_OFF, 32'h0000_4000);
		wr(`ESS_ACT_CFG_OFF, cfg[0]);
		wr(`ESS_ENC_CFG_OFF, cfg[1]);
		wr(`ESS_SSP_OFF, cfg[2]);
		wr(`ESS_SAVED_SSP_OFF, cfg[3]);
		cmd(`ESS_OP_ENTER);
		st(32'h1, 32'h7);
		rd(`ESS_ACT_CFG_OFF, cfg[1], FULL, "enclave state");
		rd(`ESS_SCR_CFG_OFF, cfg[0], FULL, "scratch state");
		rd(`ESS_SSP_OFF, cfg[3], FULL, "entry pointer");
		rd(`ESS_SCR_SSP_OFF, cfg[2], FULL, "scratch pointer");
		wr(`ESS_ACT_CFG_OFF, ~cfg[0]);
		rd(`ESS_ACT_CFG_OFF, cfg[1], FULL, "locked state");
		cmd(`ESS_OP_ENTER);
		st(32'h3, 32'h7);
		for (i = 0; i < 6; i++) begin
			wr(`ESS_ACC_ADDR_OFF, AAD[i]);
			wr(`ESS_ACC_ATTR_OFF, {24'h0, AAT[i]});
			cmd(`ESS_OP_ACCESS);
			st({29'h0, AFT[i], 1'b1}, 32'h7);
			rd(`ESS_ERR_CODE_OFF, {16'h0, AEC[i]}, FULL, "error code");
		end
		wr(`ESS_ACC_ADDR_OFF, 32'h0001_2345);
		cmd(`ESS_OP_BITMAP);
		rd(`ESS_BITMAP_OFF, 32'h2, FULL, "bitmap index");
		for (i = 0; i < 2; i++) begin
			if (i == 1) cmd(`ESS_OP_ENTER);
			cmd(i == 0 ? `ESS_OP_AEX : `ESS_OP_EXIT);
			if (i == 0) rd(`ESS_SSA_CFG_OFF, cfg[1], FULL, "saved frame");
			st(32'h0, 32'h7);
			rd(`ESS_ACT_CFG_OFF, cfg[0], FULL, "restored state");
			rd(`ESS_SSP_OFF, cfg[2], FULL, "restored pointer");
			rd(`ESS_SAVED_SSP_OFF, cfg[3], FULL, "saved pointer");
		end
		cmd(`ESS_OP_EXIT);
		st(32'h2, 32'h7);
		cmd(`ESS_OP_BITMAP);
		rd(`ESS_BITMAP_OFF, 32'h12, FULL, "absolute index");
		for (i = 0; i < 19; i++) begin
			wr(`ESS_PAGE_LA_OFF, {12'h0, LPG[i], 12'h0});
			wr(`ESS_PAGE_ATTR_OFF, {20'h0, LAT[i]});
			wr(`ESS_PAGE_DATA_OFF, {12'h0, LDT[i]});
			cmd(LOP[i]);
			st({29'h0, LFT[i], 1'b0}, 32'h6);
			rd(`ESS_PAGE_META_OFF, {24'h0, LMT[i]}, 32'hFF, "meta");
			if (i == 1) begin
				st(32'h8, 32'h8);
				rd(`ESS_TOKEN_ADDR_OFF, 32'h0001_1FF8, FULL, "token place");
				rd(`ESS_TOKEN_VAL_OFF, 32'h0001_2000, FULL, "token value");
			end
		end
		repeat (4) @(posedge SYS_CLK);
		tally_and_finish;
	end
	// about 200 transfers of at most four cycles each; ten thousand cycles is ample
	initial begin
		#1_000_000;
		failures++;
		tally_and_finish;
	end
endmodule
